// file: src/spi_pkg.sv
package spi_pkg;
  localparam int              WORD_W         = 16;
  localparam int              FIFO_DEPTH     = 8;
  localparam int              DIV_W          = 7;
  localparam int              CNT_W          = 8;
  localparam int              CTRL_W         = 8;
  localparam int              PIN_CNT        = 4;
  localparam int              ROLE_BIT       = 2;
  localparam int              PHASE_BIT      = 3;
  localparam int              POLARITY_BIT   = 6;
  localparam int              PIN_SCLK       = 0;
  localparam int              PIN_STE        = 1;
  localparam int              PIN_MOSI       = 2;
  localparam int              PIN_MISO       = 3;
  localparam logic [CNT_W-1:0] MIN_PERIOD    = 8'h04;
  localparam logic [DIV_W-1:0] DIRECT_DIV_MIN = 7'h03;
  localparam logic [4:0]      LAST_BIT       = 5'h0f;
  localparam logic [WORD_W-1:0] WORD_RESET   = 16'h0000;
  localparam logic [2:0]      SYNC_RESET     = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LEAD  = 3'b001,
    ST_ACT   = 3'b010,
    ST_INACT = 3'b011,
    ST_SLAVE = 3'b100
  } spi_state_e;
endpackage

// file: src/spi_fifo.sv
`timescale 1ns/1ps
module spi_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0]   next_count;
  logic          push;
  logic          pop;

  assign o_ready = (count != (AW+1)'(D));
  assign o_valid = (count != '0);
  assign o_data  = mem[rd_ptr];

  always_comb
  begin
    push        = i_valid && o_ready;
    pop         = i_ready && o_valid;
    next_wr_ptr = push ? ((wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage needs no reset; count guards every read
  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_data;
    end
  end
endmodule // spi_fifo

// file: src/spi_port.sv
`timescale 1ns/1ps
module spi_port
  import spi_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_reset_n,
  input  wire logic [CTRL_W-1:0] i_operation_control_reg,
  input  wire logic [CTRL_W-1:0] i_configuration_control_reg,
  input  wire logic [DIV_W-1:0]  i_bit_rate_divider,
  input  wire logic [WORD_W-1:0] i_tx_data,
  input  wire logic              i_tx_valid,
  output logic                   o_tx_ready,
  output logic [WORD_W-1:0]      o_rx_data,
  output logic                   o_rx_valid,
  output logic                   o_busy,
  input  wire logic              i_shift_clock_line,
  output logic                   o_shift_clock_line,
  output logic                   o_shift_clock_line_oe,
  input  wire logic              i_slave_enable_line_n,
  output logic                   o_slave_enable_line_n,
  output logic                   o_slave_enable_line_n_oe,
  input  wire logic              i_master_out_line,
  output logic                   o_master_out_line,
  output logic                   o_master_out_line_oe,
  input  wire logic              i_master_in_line,
  output logic                   o_master_in_line,
  output logic                   o_master_in_line_oe
);
  spi_state_e         state;
  spi_state_e         next_state;
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W-1:0]   next_cnt;
  logic [4:0]         bitcnt;
  logic [4:0]         next_bitcnt;
  logic [WORD_W-1:0]  shreg;
  logic [WORD_W-1:0]  next_shreg;
  logic               out_bit;
  logic               next_out_bit;
  logic               sclk_out;
  logic               next_sclk_out;
  logic               ste_out_n;
  logic               next_ste_out_n;
  logic               more;
  logic               next_more;
  logic [WORD_W-1:0]  rx_data;
  logic [WORD_W-1:0]  next_rx_data;
  logic               rx_valid;
  logic               next_rx_valid;
  logic [PIN_CNT-1:0] pin_in;
  logic [PIN_CNT-1:0] pin_f;
  logic               sclk_d;
  logic               ste_d;
  logic               master;
  logic               pha;
  logic               pol;
  logic [CNT_W-1:0]   period;
  logic [CNT_W-1:0]   half_act;
  logic [CNT_W-1:0]   half_inact;
  logic               ev1;
  logic               ev2;
  logic               load;
  logic               sample;
  logic [WORD_W-1:0]  fifo_data;
  logic               fifo_valid;
  logic               fifo_pop;
  logic [WORD_W-1:0]  load_word;

  assign master = i_operation_control_reg[ROLE_BIT];
  assign pha    = i_operation_control_reg[PHASE_BIT];
  assign pol    = i_configuration_control_reg[POLARITY_BIT];
  assign pin_in = {i_master_in_line, i_master_out_line, i_slave_enable_line_n, i_shift_clock_line};

  // three stages; a level is taken only once the last two agree
  genvar g;
  generate
    for (g = 0; g < PIN_CNT; g++)
    begin : g_sync
      logic [2:0] sync;
      logic [2:0] next_sync;
      logic       filt;
      logic       next_filt;
      always_comb
      begin
        next_sync = {sync[1:0], pin_in[g]};
        next_filt = (sync[1] == sync[2]) ? sync[2] : filt;
      end
      always_ff @(posedge i_mclk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          sync <= SYNC_RESET;
          filt <= 1'b0;
        end
        else
        begin
          sync <= next_sync;
          filt <= next_filt;
        end
      end
      assign pin_f[g] = filt;
    end
  endgenerate

  spi_fifo #(
    .W (WORD_W),
    .D (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_data    (i_tx_data),
    .i_valid   (i_tx_valid),
    .o_ready   (o_tx_ready),
    .o_data    (fifo_data),
    .o_valid   (fifo_valid),
    .i_ready   (fifo_pop)
  );

  always_comb
  begin
    // settings 0..2 clamp to four clocks
    period     = (i_bit_rate_divider >= DIRECT_DIV_MIN) ? {1'b0, i_bit_rate_divider} + 8'h01 : MIN_PERIOD;
    half_act   = period >> 1;
    half_inact = period - half_act;
    next_state     = state;
    next_cnt       = cnt;
    next_bitcnt    = bitcnt;
    next_shreg     = shreg;
    next_out_bit   = out_bit;
    next_sclk_out  = sclk_out;
    next_ste_out_n = ste_out_n;
    next_more      = more;
    next_rx_data   = rx_data;
    next_rx_valid  = 1'b0;
    ev1            = 1'b0;
    ev2            = 1'b0;
    load           = 1'b0;
    fifo_pop       = 1'b0;
    sample         = master ? pin_f[PIN_MISO] : pin_f[PIN_MOSI];
    load_word      = fifo_valid ? fifo_data : WORD_RESET;
    unique case (state)
      ST_IDLE:
      begin
        next_sclk_out  = pol;
        next_ste_out_n = 1'b1;
        next_bitcnt    = '0;
        if (!master)
        begin
          next_state = ST_SLAVE;
        end
        else if (fifo_valid)
        begin
          load           = 1'b1;
          next_ste_out_n = 1'b0;
          next_state     = ST_LEAD;
          next_cnt       = half_inact - 8'h01;
        end
      end
      ST_LEAD, ST_INACT:
      begin
        if (!master)
        begin
          next_state = ST_IDLE;
        end
        else if (cnt != '0)
        begin
          next_cnt = cnt - 8'h01;
        end
        else if (state == ST_LEAD || more)
        begin
          ev1           = 1'b1;
          next_sclk_out = ~pol;
          next_state    = ST_ACT;
          next_cnt      = half_act - 8'h01;
        end
        else
        begin
          // enable released only after the last idle half period
          next_ste_out_n = 1'b1;
          next_state     = ST_IDLE;
        end
      end
      ST_ACT:
      begin
        if (!master)
        begin
          next_state = ST_IDLE;
        end
        else if (cnt != '0)
        begin
          next_cnt = cnt - 8'h01;
        end
        else
        begin
          ev2           = 1'b1;
          next_sclk_out = pol;
          next_state    = ST_INACT;
          next_cnt      = half_inact - 8'h01;
        end
      end
      ST_SLAVE:
      begin
        if (master)
        begin
          next_state = ST_IDLE;
        end
        else if (pin_f[PIN_STE])
        begin
          next_bitcnt = '0;
        end
        else
        begin
          // relies on the far clock being slow enough to filter
          ev1  = (pin_f[PIN_SCLK] != pol) && (sclk_d == pol);
          ev2  = (pin_f[PIN_SCLK] == pol) && (sclk_d != pol);
          load = ste_d;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    if (ev1)
    begin
      if (pha)
      begin
        next_out_bit = shreg[WORD_W-1];
      end
      else
      begin
        next_shreg = {shreg[WORD_W-2:0], sample};
      end
    end
    if (ev2)
    begin
      if (pha)
      begin
        next_shreg = {shreg[WORD_W-2:0], sample};
      end
      else
      begin
        next_out_bit = shreg[WORD_W-1];
      end
      next_bitcnt = bitcnt + 5'h01;
      if (bitcnt == LAST_BIT)
      begin
        next_bitcnt   = '0;
        next_rx_data  = pha ? {shreg[WORD_W-2:0], sample} : shreg;
        next_rx_valid = 1'b1;
        load          = 1'b1;
      end
    end
    if (load)
    begin
      // slave with nothing queued answers zeros
      fifo_pop   = fifo_valid;
      next_shreg = load_word;
      next_more  = fifo_valid;
      if (!pha)
      begin
        next_out_bit = load_word[WORD_W-1];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state     <= ST_IDLE;
      cnt       <= '0;
      bitcnt    <= '0;
      shreg     <= WORD_RESET;
      out_bit   <= 1'b0;
      sclk_out  <= 1'b0;
      ste_out_n <= 1'b1;
      more      <= 1'b0;
      rx_data   <= WORD_RESET;
      rx_valid  <= 1'b0;
      sclk_d    <= 1'b0;
      ste_d     <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      bitcnt    <= next_bitcnt;
      shreg     <= next_shreg;
      out_bit   <= next_out_bit;
      sclk_out  <= next_sclk_out;
      ste_out_n <= next_ste_out_n;
      more      <= next_more;
      rx_data   <= next_rx_data;
      rx_valid  <= next_rx_valid;
      sclk_d    <= pin_f[PIN_SCLK];
      ste_d     <= pin_f[PIN_STE];
    end
  end

  assign o_shift_clock_line       = sclk_out;
  assign o_shift_clock_line_oe    = master;
  assign o_slave_enable_line_n    = ste_out_n;
  assign o_slave_enable_line_n_oe = master;
  assign o_master_out_line        = out_bit;
  assign o_master_out_line_oe     = master;
  assign o_master_in_line         = out_bit;
  assign o_master_in_line_oe      = !master && !pin_f[PIN_STE] && (state == ST_SLAVE);
  assign o_rx_data                = rx_data;
  assign o_rx_valid               = rx_valid;
  assign o_busy                   = (state != ST_IDLE) && (state != ST_SLAVE);
endmodule // spi_port

// file: testbench/spi_port_monitor.sv
`timescale 1ns/1ps
module spi_port_monitor
  import spi_pkg::*;
(
  input wire logic              i_mclk,
  input wire logic              i_reset_n,
  input wire logic [CTRL_W-1:0] i_operation_control_reg,
  input wire logic [CTRL_W-1:0] i_configuration_control_reg,
  input wire logic [DIV_W-1:0]  i_bit_rate_divider,
  input wire logic              o_busy,
  input wire logic              o_shift_clock_line,
  input wire logic              o_shift_clock_line_oe,
  input wire logic              o_slave_enable_line_n,
  input wire logic              o_master_out_line,
  input wire logic              o_slave_enable_line_n_oe,
  input wire logic              o_master_out_line_oe,
  input wire logic              o_master_in_line_oe
);
  logic       prev_clk, prev_en, edge_seen, role, pol, ph;
  logic [7:0] run, next_run, per, act;
  always_comb
  begin
    role = i_operation_control_reg[ROLE_BIT];
    ph = i_operation_control_reg[PHASE_BIT];
    pol = i_configuration_control_reg[POLARITY_BIT];
    per = (i_bit_rate_divider >= DIRECT_DIV_MIN) ? {1'b0, i_bit_rate_divider} + 8'h01 : MIN_PERIOD;
    act = per >> 1;
    edge_seen = o_shift_clock_line != prev_clk;
    // saturate so a long idle never wraps into a legal length
    next_run = (edge_seen || o_slave_enable_line_n != prev_en) ? 8'h01 : run + {7'h00, run != 8'hff};
  end
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prev_clk <= 1'b0;
      prev_en <= 1'b1;
      run <= 8'h00;
    end
    else
    begin
      prev_clk <= o_shift_clock_line;
      prev_en <= o_slave_enable_line_n;
      run <= next_run;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  a_clock_oe_role: assert property (o_shift_clock_line_oe == role) else $error("clock enable wrong");
  a_busy_master: assert property (o_busy |-> role) else $error("busy in slave role");
  a_pin_oe_role: assert property (o_slave_enable_line_n_oe == role && o_master_out_line_oe == role)
    else $error("pin enables do not follow role");
  a_miso_oe_slave: assert property (o_master_in_line_oe |-> !role) else $error("miso driven as master");
  a_idle_level: assert property (role && $past(i_reset_n) && $past(!o_busy) && !o_busy
    && $stable(i_configuration_control_reg) && $stable(role) |-> o_shift_clock_line == pol) else $error("idle level");
  a_enable_first: assert property (role && $past(role) && $past(i_reset_n) && o_shift_clock_line != $past(pol)
    |-> !o_slave_enable_line_n) else $error("clock left idle without enable");
  a_active_len: assert property (role && !o_slave_enable_line_n && edge_seen && o_shift_clock_line == pol
    |-> run == act) else $error("active phase length");
  a_idle_len: assert property (role && !o_slave_enable_line_n && edge_seen && o_shift_clock_line != pol
    |-> run == per - act) else $error("idle phase length");
  a_stop_len: assert property (role && o_slave_enable_line_n && !prev_en |-> run == per - act)
    else $error("enable release timing");
  a_mosi_hold: assert property (role && !o_slave_enable_line_n && edge_seen
    && ((o_shift_clock_line != pol) != ph) |-> $stable(o_master_out_line)) else $error("mosi moved at sample");
endmodule // spi_port_monitor
bind spi_port spi_port_monitor u_mon (.i_mclk, .i_reset_n, .i_operation_control_reg, .i_configuration_control_reg,
  .i_bit_rate_divider, .o_busy, .o_shift_clock_line, .o_shift_clock_line_oe, .o_slave_enable_line_n,
  .o_master_out_line, .o_slave_enable_line_n_oe, .o_master_out_line_oe, .o_master_in_line_oe);

// file: testbench/spi_far_end.sv
`timescale 1ns/1ps
module spi_far_end
  import spi_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_sclk,
  input  wire logic              i_en_n,
  input  wire logic              i_mosi,
  input  wire logic              i_miso,
  input  wire logic              i_phase,
  input  wire logic              i_pol,
  input  wire logic [WORD_W-1:0] i_word,
  output logic                   o_miso,
  output logic                   o_sclk,
  output logic                   o_en_n,
  output logic                   o_mosi,
  output logic [WORD_W-1:0]      o_rx
);
  logic [WORD_W-1:0] sh;
  initial
  begin
    o_sclk = 1'b0;
    o_en_n = 1'b1;
    o_mosi = 1'b0;
    o_miso = 1'b0;
    o_rx = '0;
  end
  always @(negedge i_en_n)
  begin
    sh = i_word;
    o_miso = i_word[WORD_W-1];
  end
  // no pull on the line: show a changed level once released
  always @(posedge i_en_n) o_miso = ~o_miso;
  always @(i_sclk)
    if (!i_en_n && o_en_n)
    begin
      if ((i_sclk != i_pol) != i_phase)
        o_rx = {o_rx[WORD_W-2:0], i_mosi};
      else if (i_phase)
      begin
        o_miso = sh[WORD_W-1];
        sh = {sh[WORD_W-2:0], sh[WORD_W-1]};
      end
      else
      begin
        sh = {sh[WORD_W-2:0], sh[WORD_W-1]};
        o_miso = sh[WORD_W-1];
      end
    end
  task automatic run_master(input logic [WORD_W-1:0] w, input int half);
    o_sclk = i_pol;
    repeat (half) @(negedge i_mclk);
    o_en_n = 1'b0;
    o_mosi = w[WORD_W-1];
    for (int b = WORD_W-1; b >= 0; b--)
    begin
      repeat (half) @(negedge i_mclk);
      o_sclk = ~i_pol;
      if (i_phase)
        o_mosi = w[b];
      else
        o_rx = {o_rx[WORD_W-2:0], i_miso};
      repeat (half) @(negedge i_mclk);
      o_sclk = i_pol;
      if (i_phase)
        o_rx = {o_rx[WORD_W-2:0], i_miso};
      else if (b > 0)
        o_mosi = w[b-1];
    end
    repeat (half) @(negedge i_mclk);
    o_en_n = 1'b1;
    o_mosi = ~o_mosi;
  endtask
endmodule // spi_far_end

// file: testbench/tb_spi_port.sv
`timescale 1ns/1ps
module tb_spi_port
  import spi_pkg::*;
;
  logic              mclk, rst_n, tx_valid, tx_ready, rx_valid, busy;
  logic              sclk_o, sclk_oe, en_o, en_oe, mosi_o, mosi_oe, miso_o, miso_oe, f_sclk, f_en, f_mosi, f_miso;
  logic [CTRL_W-1:0] ctl, cfg;
  logic [DIV_W-1:0]  div;
  logic [WORD_W-1:0] tx_data, rx_data, far_rx, reply;
  wire logic         sclk = sclk_oe ? sclk_o : f_sclk;
  wire logic         en_n = en_oe ? en_o : f_en;
  wire logic         mosi = mosi_oe ? mosi_o : f_mosi;
  wire logic         miso = miso_oe ? miso_o : f_miso;
  int                miscompares = 0, cmp_count = 0, cyc = 0;
  spi_port dut (.i_mclk(mclk), .i_reset_n(rst_n), .i_operation_control_reg(ctl), .i_configuration_control_reg(cfg),
    .i_bit_rate_divider(div), .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_busy(busy), .i_shift_clock_line(sclk),
    .o_shift_clock_line(sclk_o), .o_shift_clock_line_oe(sclk_oe), .i_slave_enable_line_n(en_n),
    .o_slave_enable_line_n(en_o), .o_slave_enable_line_n_oe(en_oe), .i_master_out_line(mosi),
    .o_master_out_line(mosi_o), .o_master_out_line_oe(mosi_oe), .i_master_in_line(miso),
    .o_master_in_line(miso_o), .o_master_in_line_oe(miso_oe));
  spi_far_end far (.i_mclk(mclk), .i_sclk(sclk), .i_en_n(en_n), .i_mosi(mosi), .i_miso(miso),
    .i_phase(ctl[PHASE_BIT]), .i_pol(cfg[POLARITY_BIT]), .i_word(reply), .o_miso(f_miso), .o_sclk(f_sclk),
    .o_en_n(f_en), .o_mosi(f_mosi), .o_rx(far_rx));
  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    check({15'h0000, got}, {15'h0000, exp}, what);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic set_mode(input logic role, input logic ph, input logic pol, input logic [DIV_W-1:0] d);
    // never change the mode under a running master transfer or its closing idle half
    do @(negedge mclk); while (busy !== 1'b0);
    @(negedge mclk);
    ctl = {4'h0, ph, role, 2'h0};
    cfg = {1'b0, pol, 6'h00};
    div = d;
    repeat (2) @(negedge mclk);
  endtask
  task automatic push(input logic [WORD_W-1:0] w);
    @(negedge mclk);
    tx_data = w;
    tx_valid = 1'b1;
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask
  // pulse lasts a full cycle, so the falling edge always sees it
  task automatic wait_rx;
    do @(negedge mclk); while (rx_valid !== 1'b1);
  endtask
  task automatic t_master_modes;
    logic [DIV_W-1:0] divs [4] = '{7'h02, 7'h04, 7'h09, 7'h0a};
    for (int i = 0; i < 4; i++)
    begin
      set_mode(1'b1, i[0], i[1], divs[i]);
      reply = 16'ha5c3 ^ 16'(i);
      push(16'hc35a + 16'(i));
      wait_rx;
      check(far_rx, 16'hc35a + 16'(i), "mosi word");
      // short periods leave no room for the input synchroniser
      if (i > 1)
        check(rx_data, reply, "miso word");
    end
  endtask
  task automatic t_stream;
    // period ten leaves room for the input synchroniser on the return line
    set_mode(1'b1, 1'b0, 1'b0, 7'h09);
    push(16'h0ff0);
    push(16'hf00f);
    wait_rx;
    check(far_rx, 16'h0ff0, "first word");
    // past the closing idle half a lone word would have released the enable
    repeat (5) @(negedge mclk);
    check_bit(en_o, 1'b0, "enable held");
    wait_rx;
    check(far_rx, 16'hf00f, "second word");
    check(rx_data, reply, "stream miso");
  endtask
  task automatic t_fill_drain;
    set_mode(1'b0, 1'b0, 1'b0, 7'h03);
    for (int k = 0; k < 9; k++)
    begin
      push(16'h1200 + 16'(k));
      check_bit(tx_ready, k < 7, "ready");
    end
    set_mode(1'b1, 1'b0, 1'b0, 7'h03);
    for (int k = 0; k < 8; k++)
    begin
      wait_rx;
      check(far_rx, 16'h1200 + 16'(k), "drained word");
    end
    check_bit(tx_ready, 1'b1, "ready after drain");
  endtask
  task automatic t_slave;
    for (int k = 0; k < 2; k++)
    begin
      set_mode(1'b0, k[0], k[0], 7'h03);
      push(16'h6b00 + 16'(k));
      fork
        far.run_master(16'h5a00 + 16'(k), 6);
        wait_rx;
      join
      check(far_rx, 16'h6b00 + 16'(k), "slave out");
      check(rx_data, 16'h5a00 + 16'(k), "slave in");
    end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict;
    end
  end
  initial
  begin
    rst_n = 1'b0;
    ctl = 8'h00;
    cfg = 8'h00;
    div = 7'h03;
    tx_data = 16'h0000;
    tx_valid = 1'b0;
    reply = 16'h0000;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    t_master_modes;
    t_stream;
    t_fill_drain;
    t_slave;
    give_verdict;
  end
endmodule // tb_spi_port
